/* core/hbms_defines.vh */
// Constants for the host bus master/slave signal block
// Behaviour
// - Direction low during direct I/O writes and DMA reads.
// - Direction high during direct I/O reads and DMA writes.
// - Direction high by default when idle.
// - Grant active low from arbiter, synchronised to system bus clock.
// - Bus request driven low before DMA, high otherwise.
// - Interrupt acknowledge low puts interrupt vector on data bus while device does not own bus.
// - Style select high picks read/write strobes, low picks address/data strobes.
// - Address/data strobe style always uses 16-bit data path.
// - Interrupt request low while interrupt pending, high otherwise.
// - Bus-owned output low while device controls bus.
// - Driver of high byte lane drives odd parity bit for it.
// - Driver of low byte lane drives odd parity bit for it.
// - Address strobe is input during direct I/O, driven during DMA.
// - As master, address strobe low while address valid and transfer runs.
// - Take bus only when busy input reads high and grant holds.
// - Release input low during DMA: release after cycle, rearbitrate.
`ifndef HBMS_DEFINES_VH
`define HBMS_DEFINES_VH
`define HBMS_ST_IDLE   3'H0
`define HBMS_ST_REQ    3'H1
`define HBMS_ST_ADDR   3'H2
`define HBMS_ST_DATA   3'H3
`define HBMS_ST_REL    3'H4
`define HBMS_ST_W      3
`define HBMS_VEC_RST   8'H0F
`define HBMS_CYC_LEN   2'H2
`endif

/* core/hbms_parity.v */
// Odd parity generator and checker for one byte lane
`timescale 1ns/10ps
`default_nettype none
module hbms_parity (
  input  wire [7:0] byte_i,   // Lane byte
  input  wire       par_i,    // Received parity bit
  output wire       par_o,    // Odd parity bit for byte
  output wire       err_o     // Received parity mismatch
);
  // Odd parity: ones in byte plus bit is odd
  assign par_o = ~(^byte_i);
  assign err_o = (^byte_i) == par_i;
endmodule
`default_nettype wire

/* core/hbms_sync2.v */
// Two-flop level synchroniser with settable reset level
`timescale 1ns/10ps
`default_nettype none
module hbms_sync2 #(
  parameter RST_VAL = 1'b1
) (
  input  wire clk_sys_i,  // System clock
  input  wire rst_n_i,    // Sync reset, active low
  input  wire d_i,        // Asynchronous level
  output wire q_o         // Synchronised level
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule
`default_nettype wire

/* core/hbms_top.v */
// Host bus master/slave signal control: arbitration, direction, strobe, parity
`timescale 1ns/10ps
`default_nettype none
`include "hbms_defines.vh"
module hbms_top #(
  parameter VEC_W = 8
) (
  input  wire             clk_sys_i,           // System bus clock
  input  wire             rst_n_i,             // Sync reset, active low
  input  wire             style_sel_i,         // 1 read/write strobe, 0 addr/data strobe
  input  wire             width8_sel_i,        // 1 asks 8-bit path
  output wire             path16_o,            // Data path is 16 bits
  input  wire             direct_io_access_i,  // Direct I/O access active
  input  wire             dio_read_i,          // Direct I/O access is a read
  input  wire             dma_start_i,         // DMA transfer pending
  input  wire             dma_write_i,         // DMA writes to host
  input  wire             dma_last_i,          // Current cycle is last of transfer
  output wire             dma_cycle_done_o,    // Pulse, one DMA cycle finished
  output wire             dma_done_o,          // Pulse, transfer finished
  input  wire             bus_grant_n_i,       // Arbiter grant, active low
  input  wire             bus_busy_in_i,       // Low forbids taking bus
  input  wire             bus_release_in_i,    // Low asks for bus release
  output reg              bus_request_n_o,     // Bus request, active low
  output reg              bus_owned_n_o,       // Bus owned, active low
  output reg              data_buffer_direction_o, // 1 out of device, 0 in
  input  wire             address_strobe_n_i,  // Address strobe pin in
  output reg              address_strobe_n_o,  // Address strobe pin out
  output reg              address_strobe_n_oe_o, // Strobe drive enable
  input  wire             irq_pending_i,       // Internal interrupt pending
  output reg              interrupt_request_n_o, // Interrupt request, active low
  input  wire             interrupt_ack_n_i,   // Interrupt acknowledge, active low
  input  wire [VEC_W-1:0] irq_vector_i,        // Interrupt vector
  input  wire [15:0]      lane_data_i,         // Device data for both lanes
  input  wire [15:0]      bus_data_i,          // Lane pins in
  output reg  [15:0]      bus_data_o,          // Lane pins out
  output reg              bus_data_oe_o,       // Lane drive enable
  input  wire             parity_high_lane_i,  // High lane parity pin in
  input  wire             parity_low_lane_i,   // Low lane parity pin in
  output reg              parity_high_lane_o,  // High lane parity pin out
  output reg              parity_low_lane_o,   // Low lane parity pin out
  output reg              parity_oe_o,         // Parity drive enable
  output reg              parity_err_o         // Received parity error, registered
);
  localparam ST_IDLE = `HBMS_ST_IDLE;
  localparam ST_REQ  = `HBMS_ST_REQ;
  localparam ST_ADDR = `HBMS_ST_ADDR;
  localparam ST_DATA = `HBMS_ST_DATA;
  localparam ST_REL  = `HBMS_ST_REL;

  wire grant_s;
  wire busy_s;
  wire rel_s;
  wire par_h;
  wire par_l;
  wire err_h;
  wire err_l;
  reg [`HBMS_ST_W-1:0] state_q;
  reg [`HBMS_ST_W-1:0] state_d;
  reg [1:0]            cnt_q;
  reg                  ack_drive;
  reg [15:0]           out_word;

  // Grant low means granted
  hbms_sync2 #(.RST_VAL(1'b1)) u_sync_grant (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       (bus_grant_n_i),
    .q_o       (grant_s)
  );
  hbms_sync2 #(.RST_VAL(1'b0)) u_sync_busy (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       (bus_busy_in_i),
    .q_o       (busy_s)
  );
  hbms_sync2 #(.RST_VAL(1'b1)) u_sync_rel (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       (bus_release_in_i),
    .q_o       (rel_s)
  );

  // Read/write strobe style may still pick 8 bits; the other style never
  assign path16_o = ~style_sel_i | ~width8_sel_i;

  // Strobe pin input is left unread; it never acts as a strobe here

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (dma_start_i)
          state_d = ST_REQ;
      end
      ST_REQ: begin
        if (!grant_s && busy_s)
          state_d = ST_ADDR;
      end
      ST_ADDR: begin
        state_d = ST_DATA;
      end
      ST_DATA: begin
        if (cnt_q == `HBMS_CYC_LEN) begin
          if (dma_last_i || !rel_s)
            state_d = ST_REL;
          else
            state_d = ST_ADDR;
        end
      end
      ST_REL: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // True while the arbitration state holds the bus
  function owns_bus;
    input [`HBMS_ST_W-1:0] st;
    begin
      owns_bus = (st == ST_ADDR) || (st == ST_DATA);
    end
  endfunction

  wire in_dma = owns_bus(state_q);
  wire cyc_end = (state_q == ST_DATA) && (cnt_q == `HBMS_CYC_LEN);
  reg last_q;
  assign dma_cycle_done_o = cyc_end;
  assign dma_done_o = cyc_end && dma_last_i;

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 2'H0;
      last_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      last_q  <= dma_last_i;
      if (state_q == ST_DATA && cnt_q != `HBMS_CYC_LEN)
        cnt_q <= cnt_q + 2'H1;
      else
        cnt_q <= 2'H0;
    end
  end

  // Release unfinished transfer rearbitrates: back to request
  wire rearb = (state_q == ST_REL) && !last_q && dma_start_i;

  always @* begin
    ack_drive = !interrupt_ack_n_i && !in_dma;
    out_word = lane_data_i;
    if (ack_drive)
      out_word = {{(16-VEC_W){1'b0}}, irq_vector_i};
  end

  // Generators see the word being launched, so lanes and parity leave together
  hbms_parity u_gen_h (
    .byte_i (out_word[15:8]),
    .par_i  (1'b0),
    .par_o  (par_h),
    .err_o  ()
  );
  hbms_parity u_gen_l (
    .byte_i (out_word[7:0]),
    .par_i  (1'b0),
    .par_o  (par_l),
    .err_o  ()
  );
  // Checkers see the pins, whoever drives them
  hbms_parity u_chk_h (
    .byte_i (bus_data_i[15:8]),
    .par_i  (parity_high_lane_i),
    .par_o  (),
    .err_o  (err_h)
  );
  hbms_parity u_chk_l (
    .byte_i (bus_data_i[7:0]),
    .par_i  (parity_low_lane_i),
    .par_o  (),
    .err_o  (err_l)
  );

  // Next values of the registered pin outputs
  reg own_d;
  reg req_d;
  reg dir_d;
  reg strobe_d;
  reg drive_d;
  reg perr_d;

  always @* begin
    own_d = owns_bus(state_d);
    // Rearbitration drives the request low from the idle clock after the release state
    req_d = (state_d == ST_REQ) || rearb;
    // Ownership wins over a direct access that overlaps it
    if (own_d)
      dir_d = dma_write_i;
    else if (direct_io_access_i)
      dir_d = dio_read_i;
    else
      dir_d = 1'b1;
    // Strobe stays high in the address clock, low in the data clocks
    strobe_d = (state_d == ST_DATA);
    drive_d = ack_drive || (in_dma && dma_write_i)
              || (direct_io_access_i && dio_read_i && !in_dma);
    // Only a received word is checked; our own drive would mask the pins
    perr_d = !bus_data_oe_o && (in_dma || direct_io_access_i)
             && (err_h || err_l);
  end

  // Arbitration and ownership pins
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_request_n_o <= 1'b1;
      bus_owned_n_o   <= 1'b1;
    end else begin
      bus_request_n_o <= !req_d;
      bus_owned_n_o   <= !own_d;
    end
  end

  // Direction and address strobe
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      data_buffer_direction_o <= 1'b1;
      address_strobe_n_o      <= 1'b1;
      address_strobe_n_oe_o   <= 1'b0;
    end else begin
      data_buffer_direction_o <= dir_d;
      address_strobe_n_o      <= !strobe_d;
      address_strobe_n_oe_o   <= own_d;
    end
  end

  // Interrupt request
  always @(posedge clk_sys_i) begin
    if (!rst_n_i)
      interrupt_request_n_o <= 1'b1;
    else
      interrupt_request_n_o <= !irq_pending_i;
  end

  // Lane data, parity and their enables
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_data_o         <= 16'H0000;
      bus_data_oe_o      <= 1'b0;
      parity_high_lane_o <= 1'b1;
      parity_low_lane_o  <= 1'b1;
      parity_oe_o        <= 1'b0;
      parity_err_o       <= 1'b0;
    end else begin
      bus_data_o         <= out_word;
      bus_data_oe_o      <= drive_d;
      parity_high_lane_o <= par_h;
      parity_low_lane_o  <= par_l;
      parity_oe_o        <= drive_d;
      parity_err_o       <= perr_d;
    end
  end
endmodule
`default_nettype wire

/* verification/hbms_arbiter_model.sv */
// Bus arbiter model: grants after a request, promptly or slowly
`timescale 1ns/10ps
`default_nettype none
module hbms_arbiter_model (
  input  wire logic clk_sys_i,       // System bus clock
  input  wire logic bus_request_n_i, // Request from device
  input  wire logic bus_owned_n_i,   // Ownership from device
  input  wire logic slow_i,          // Delay the grant
  output var  logic bus_grant_n_o    // Grant, active low
);
  logic [2:0] wait_q = 3'H0;
  initial bus_grant_n_o = 1'b1;
  // Grant kept while the device holds the bus
  always @(negedge clk_sys_i) begin
    if (bus_request_n_i && bus_owned_n_i) begin
      bus_grant_n_o <= 1'b1;
      wait_q <= 3'H0;
    end else if (wait_q >= (slow_i ? 3'H5 : 3'H0)) begin
      bus_grant_n_o <= 1'b0;
    end else begin
      wait_q <= wait_q + 3'H1;
    end
  end
endmodule
`default_nettype wire

/* verification/hbms_checker.sv */
// Concurrent checks on the host bus signal block ports
`timescale 1ns/10ps
`default_nettype none
module hbms_checker #(parameter VEC_W = 8) (
  input wire logic clk_sys_i, rst_n_i, style_sel_i, path16_o, dma_start_i, // Clock, mode
  input wire logic direct_io_access_i, dio_read_i, dma_write_i, dma_cycle_done_o, // Transfer
  input wire logic bus_grant_n_i, bus_busy_in_i, bus_release_in_i, dma_done_o, // Arbitration
  input wire logic bus_request_n_o, bus_owned_n_o, data_buffer_direction_o, // Bus control
  input wire logic address_strobe_n_o, address_strobe_n_oe_o, irq_pending_i, // Strobe
  input wire logic interrupt_request_n_o, interrupt_ack_n_i, bus_data_oe_o, parity_oe_o, // Irq
  input wire logic parity_high_lane_o, parity_low_lane_o, // Lane parity
  input wire logic [VEC_W-1:0] irq_vector_i, // Vector
  input wire logic [15:0]      bus_data_o    // Lane pins
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_idle_dir: assert property ($past(!direct_io_access_i) && bus_owned_n_o |->
    data_buffer_direction_o) else $error("direction low while idle");
  a_dio_dir: assert property ($past(direct_io_access_i) && bus_owned_n_o |->
    data_buffer_direction_o == $past(dio_read_i)) else $error("direct io direction wrong");
  a_dma_dir: assert property (!bus_owned_n_o |->
    data_buffer_direction_o == $past(dma_write_i)) else $error("dma direction wrong");
  a_wide_path: assert property (!style_sel_i |-> path16_o)
    else $error("path not 16 bits");
  a_irq_follow: assert property (interrupt_request_n_o == !$past(irq_pending_i))
    else $error("interrupt request wrong");
  a_strobe_drive: assert property (address_strobe_n_oe_o == !bus_owned_n_o &&
    (address_strobe_n_oe_o || address_strobe_n_o))
    else $error("strobe enable wrong");
  a_req_answer: assert property ($rose(dma_start_i) && bus_owned_n_o |=>
    !bus_request_n_o) else $error("no bus request");
  a_own_grant: assert property ($fell(bus_owned_n_o) |->
    $past(!bus_grant_n_i, 3) && $past(bus_busy_in_i, 3)) else $error("bus taken unasked");
  a_addr_strobe: assert property ($fell(bus_owned_n_o) |=> !address_strobe_n_o)
    else $error("address strobe not low");
  a_rel_after: assert property (dma_cycle_done_o && $past(!bus_release_in_i, 2) &&
    $past(!bus_release_in_i, 3) |=> bus_owned_n_o) else $error("bus not released");
  a_lane_par: assert property (parity_oe_o |->
    parity_high_lane_o == ~^bus_data_o[15:8] && parity_low_lane_o == ~^bus_data_o[7:0])
    else $error("lane parity not odd");
  a_vec_out: assert property ($past(!interrupt_ack_n_i) && $past(!direct_io_access_i) &&
    bus_owned_n_o && $past(bus_owned_n_o) |-> bus_data_oe_o &&
    bus_data_o == 16'($past(irq_vector_i))) else $error("vector not driven");
  c_dma_done: cover property (dma_done_o);
  c_vector: cover property (!interrupt_ack_n_i && bus_data_oe_o);
  c_release: cover property (dma_cycle_done_o && !bus_release_in_i);
endmodule
`default_nettype wire

/* verification/tb_host_bus_master_slave_signals.sv */
// Testbench for the host bus signal block with an arbiter model
`timescale 1ns/10ps
`default_nettype none
module tb_host_bus_master_slave_signals;
  localparam int VEC_W = 8;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, style_sel_i = 1'b0, width8_sel_i = 1'b1;
  logic direct_io_access_i = 1'b0, dio_read_i = 1'b0, dma_start_i = 1'b0, dma_write_i = 1'b0;
  logic dma_last_i = 1'b1, bus_busy_in_i = 1'b1, bus_release_in_i = 1'b1, slow = 1'b0;
  logic irq_pending_i = 1'b0, interrupt_ack_n_i = 1'b1, par_lo_pin = 1'b1;
  logic [VEC_W-1:0] irq_vector_i = 8'H5B;
  logic [15:0]      lane_data_i = 16'H0137;
  wire logic path16_o, dma_cycle_done_o, dma_done_o, bus_grant_n_i, bus_request_n_o;
  wire logic bus_owned_n_o, data_buffer_direction_o, address_strobe_n_o, address_strobe_n_oe_o;
  wire logic interrupt_request_n_o, bus_data_oe_o, parity_high_lane_o, parity_low_lane_o;
  wire logic parity_oe_o, parity_err_o;
  wire logic [15:0] bus_data_o;
  int fail_count = 0, compares = 0, cyc = 0;
  // Undriven pins sit at their pull-up level, which is odd parity
  hbms_top #(.VEC_W(VEC_W)) i_dut (.address_strobe_n_i(1'b1), .bus_data_i(16'HFFFF),
    .parity_high_lane_i(1'b1), .parity_low_lane_i(par_lo_pin), .*);
  hbms_arbiter_model i_arb (.clk_sys_i(clk_sys_i), .bus_request_n_i(bus_request_n_o),
    .bus_owned_n_i(bus_owned_n_o), .slow_i(slow), .bus_grant_n_o(bus_grant_n_i));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  task automatic tick(int n = 1);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_idle();
    check("direction", 1, data_buffer_direction_o);
    check("request", 1, bus_request_n_o);
    check("owned", 1, bus_owned_n_o);
    check("strobe drive", 0, address_strobe_n_oe_o);
  endtask
  task automatic t_style();
    style_sel_i = 1'b1;
    tick();
    check("path16", 0, path16_o);
    width8_sel_i = 1'b0;
    tick();
    check("path16", 1, path16_o);
    width8_sel_i = 1'b1;
    style_sel_i = 1'b0;
    tick();
    check("path16", 1, path16_o);
  endtask
  task automatic t_dio();
    direct_io_access_i = 1'b1;
    dio_read_i = 1'b1;
    tick(2);
    check("direction", 1, data_buffer_direction_o);
    check("lane drive", 1, bus_data_oe_o);
    check("lanes", 16'H0137, bus_data_o);
    check("parity", 16'H0, {parity_high_lane_o, parity_low_lane_o});
    dio_read_i = 1'b0;
    par_lo_pin = 1'b0;
    tick(2);
    check("direction", 0, data_buffer_direction_o);
    check("lane drive", 0, bus_data_oe_o);
    check("parity error", 1, parity_err_o);
    par_lo_pin = 1'b1;
    tick(2);
    check("parity error", 0, parity_err_o);
    direct_io_access_i = 1'b0;
    tick(2);
    check("direction", 1, data_buffer_direction_o);
  endtask
  task automatic t_irq();
    irq_pending_i = 1'b1;
    tick();
    check("irq", 0, interrupt_request_n_o);
    interrupt_ack_n_i = 1'b0;
    tick();
    check("vector", 16'H005B, bus_data_o);
    check("parity", 16'H2, {parity_high_lane_o, parity_low_lane_o});
    interrupt_ack_n_i = 1'b1;
    irq_pending_i = 1'b0;
    tick();
    check("irq", 1, interrupt_request_n_o);
  endtask
  task automatic t_dma(logic wr, logic sl, logic busy, logic rel);
    bit own = 0, strb = 0, sent = 0, cdone = 0;
    dma_write_i = wr;
    slow = sl;
    bus_busy_in_i = !busy;
    dma_last_i = !rel;
    dma_start_i = 1'b1;
    tick(2);
    check("request", 0, bus_request_n_o);
    if (busy) begin
      tick(8);
      check("owned", 1, bus_owned_n_o);
      check("request", 0, bus_request_n_o);
    end
    bus_busy_in_i = 1'b1;
    for (int n = 0; n < 40 && !dma_done_o; n++) begin
      tick();
      if (rel && !sent && !bus_owned_n_o) begin
        bus_release_in_i = 1'b0;
        sent = 1;
      end
      if (rel && !bus_release_in_i && !bus_request_n_o) begin
        bus_release_in_i = 1'b1;
        dma_last_i = 1'b1;
        check("rearbitrate", 1, bus_owned_n_o);
      end
      if (!bus_owned_n_o) begin
        check("dma direction", wr, data_buffer_direction_o);
        check("strobe drive", 1, address_strobe_n_oe_o);
      end
      own |= !bus_owned_n_o;
      strb |= !address_strobe_n_o;
      cdone |= dma_cycle_done_o;
    end
    check("done", 1, dma_done_o);
    check("cycle done", 1, cdone);
    check("seen owned", 1, own);
    check("seen strobe", 1, strb);
    dma_start_i = 1'b0;
    tick(2);
    t_idle();
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    tick(10);
    rst_n_i = 1'b1;
    tick(3);
    t_idle();
    t_style();
    t_dio();
    t_irq();
    t_dma(1'b0, 1'b0, 1'b0, 1'b0);
    t_dma(1'b1, 1'b1, 1'b1, 1'b0);
    t_dma(1'b0, 1'b0, 1'b0, 1'b1);
    final_report();
  end
endmodule
bind hbms_top hbms_checker #(.VEC_W(VEC_W)) i_chk (.*);
`default_nettype wire
